// >>> rtl/static_link_fwd.sv
// per-link static forwarding: registers, arbitration and the two output streams
//
// What this block does
// RULE_01: bit 31 of each link's register puts that link in static mode, clear means routed.
// RULE_02: traffic from a static link goes only to its chosen channel end with no route lookup.
// RULE_03: bits 4..0 of each register, read-write, choose the receiving local channel end.
// RULE_04: the eight registers from lowest to highest map to links c, d, b, a, g, h, e, f.
// RULE_05: bits 30..5 are reserved, read as zero and ignore writes.
// RULE_06: after reset every enable bit and destination field is zero.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module static_link_fwd (
    input  wire logic                                                  clk_i,
    input  wire logic                                                  rst_i,
    // classic wishbone slave
    input  wire logic                                                  cyc_i,
    input  wire logic                                                  stb_i,
    input  wire logic                                                  we_i,
    input  wire logic [static_fwd_pkg::ADR_W-1:0]                      adr_i,
    input  wire logic [3:0]                                            sel_i,
    input  wire logic [31:0]                                           dat_i,
    output logic [31:0]                                                dat_o,
    output logic                                                       ack_o,
    // incoming link tokens, one lane per link numbered a..h
    input  wire logic [static_fwd_pkg::NUM_LINKS-1:0]                  link_valid_i,
    input  wire logic [static_fwd_pkg::NUM_LINKS*static_fwd_pkg::TOKEN_W-1:0] link_data_i,
    output logic [static_fwd_pkg::NUM_LINKS-1:0]                       link_ready_o,
    // static traffic towards local channel ends
    output logic                                                       chan_valid_o,
    input  wire logic                                                  chan_ready_i,
    output logic [static_fwd_pkg::TOKEN_W-1:0]                         chan_data_o,
    output logic [static_fwd_pkg::CHANEND_W-1:0]                       chan_dest_o,
    // routed traffic towards the route lookup
    output logic                                                       route_valid_o,
    input  wire logic                                                  route_ready_i,
    output logic [static_fwd_pkg::TOKEN_W-1:0]                         route_data_o,
    output logic [static_fwd_pkg::LINK_IDX_W-1:0]                      route_link_o
);

    localparam int N  = static_fwd_pkg::NUM_LINKS;
    localparam int TW = static_fwd_pkg::TOKEN_W;
    localparam int CW = static_fwd_pkg::CHANEND_W;
    localparam int LW = static_fwd_pkg::LINK_IDX_W;

    ////////////////////////////////////////////////////////////////////////////////
    // register bus decode

    logic                 req;
    logic                 cfg_hit;
    logic                 status_hit;
    logic [LW-1:0]        slot;
    logic                 wr_fire;
    logic [N-1:0]         cfg_en;
    logic [CW-1:0]        cfg_dest [N];
    logic [static_fwd_pkg::CNT_W-1:0] static_cnt;
    logic [static_fwd_pkg::CNT_W-1:0] routed_cnt;

    // a new request is one not yet answered; ack drops the cycle after it rises
    assign req        = cyc_i && stb_i && !ack_o;
    // RULE_04: eight consecutive words from the base
    assign cfg_hit    = (adr_i[static_fwd_pkg::ADR_W-1:5] ==
                         static_fwd_pkg::CFG_BASE_ADR[static_fwd_pkg::ADR_W-1:5]);
    assign status_hit = (adr_i[static_fwd_pkg::ADR_W-1:2] ==
                         static_fwd_pkg::STATUS_ADR[static_fwd_pkg::ADR_W-1:2]);
    assign slot       = adr_i[4:2];
    assign wr_fire    = req && we_i && cfg_hit;

    // one register per slot, steered to the link that slot controls
    genvar s;
    generate
        for (s = 0; s < N; s++) begin : g_cfg
            localparam logic [LW-1:0] LNK = static_fwd_pkg::slot_link(3'(s));
            // RULE_04: slot to link mapping
            link_cfg_reg u_cfg (
                .clk_i    (clk_i),
                .rst_i    (rst_i),
                .wr_i     (wr_fire && slot == 3'(s)),
                .sel_i    (sel_i),
                .dat_i    (dat_i),
                .enable_o (cfg_en[LNK]),
                .dest_o   (cfg_dest[LNK])
            );
        end
    endgenerate

    // every address answers in one cycle; unmapped reads give zero, writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // read data; reserved bits of the configuration registers read as zero
    // RULE_05: reserved bits read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            if (cfg_hit) begin
                dat_o <= {cfg_en[static_fwd_pkg::slot_link(slot)], 26'h000_0000,
                          cfg_dest[static_fwd_pkg::slot_link(slot)]};
            end else if (status_hit) begin
                dat_o <= {routed_cnt, static_cnt};
            end else begin
                dat_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // arbitration among the links

    logic [N-1:0]   grant_pending;
    logic [LW-1:0]  gnt_idx;
    logic           gnt_static;
    logic [CW-1:0]  gnt_dest;
    logic           xfer;
    logic [TW-1:0]  xfer_data;
    logic           push_chan;
    logic           push_route;
    logic [1:0]     chan_cnt;
    logic [1:0]     route_cnt;
    logic           chan_pop;
    logic           route_pop;
    logic           chan_room;
    logic           route_room;
    logic [N-1:0]   next_grant;
    logic [LW-1:0]  next_idx;
    logic           next_found;
    logic [LW-1:0]  cand;

    assign link_ready_o = grant_pending;
    assign xfer         = |(link_valid_i & link_ready_o);
    assign xfer_data    = link_data_i[gnt_idx*TW +: TW];
    // RULE_02: static traffic bypasses the route path
    assign push_chan    = xfer && gnt_static;
    assign push_route   = xfer && !gnt_static;
    assign chan_pop     = chan_valid_o && chan_ready_i;
    assign route_pop    = route_valid_o && route_ready_i;

    // room after this edge: a granted word can always be absorbed, so nothing is lost
    always_comb begin
        chan_room  = (3'(chan_cnt) + 3'(push_chan) - 3'(chan_pop)) < 3'h2;
        route_room = (3'(route_cnt) + 3'(push_route) - 3'(route_pop)) < 3'h2;
    end

    // round robin from the link after the last grant; only links whose target
    // buffer has room compete, so a stalled channel end does not block routed links
    // RULE_01: mode picks the target buffer
    always_comb begin
        next_grant = '0;
        next_idx   = gnt_idx;
        next_found = 1'b0;
        cand       = '0;
        for (int k = 1; k <= N; k++) begin
            cand = gnt_idx + LW'(k);
            if (!next_found && link_valid_i[cand] &&
                (cfg_en[cand] ? chan_room : route_room)) begin
                next_found       = 1'b1;
                next_idx         = cand;
                next_grant[cand] = 1'b1;
            end
        end
    end

    // mode and destination are frozen at grant time so a register write
    // landing mid-transfer cannot steer a word into a buffer with no room
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            grant_pending <= '0;
            gnt_idx       <= '0;
            gnt_static    <= 1'b0;
            gnt_dest      <= '0;
        end else begin
            grant_pending <= next_grant;
            gnt_idx       <= next_idx;
            gnt_static    <= cfg_en[next_idx];
            gnt_dest      <= cfg_dest[next_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output buffers

    // RULE_03: chosen channel end travels with the token
    fwd_buffer #(
        .WIDTH (CW + TW)
    ) u_chan_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_chan),
        .in_ready_o  (),
        .in_data_i   ({gnt_dest, xfer_data}),
        .out_valid_o (chan_valid_o),
        .out_ready_i (chan_ready_i),
        .out_data_o  ({chan_dest_o, chan_data_o}),
        .count_o     (chan_cnt)
    );

    fwd_buffer #(
        .WIDTH (LW + TW)
    ) u_route_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_route),
        .in_ready_o  (),
        .in_data_i   ({gnt_idx, xfer_data}),
        .out_valid_o (route_valid_o),
        .out_ready_i (route_ready_i),
        .out_data_o  ({route_link_o, route_data_o}),
        .count_o     (route_cnt)
    );

    // word counters seen by software, wrapping
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            static_cnt <= '0;
            routed_cnt <= '0;
        end else begin
            static_cnt <= static_cnt + static_fwd_pkg::CNT_W'(push_chan);
            routed_cnt <= routed_cnt + static_fwd_pkg::CNT_W'(push_route);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    reset_routed_a: assert property (@(posedge clk_i) // RULE_06
        rst_i |=> (cfg_en == '0 && cfg_dest[0] == '0 && cfg_dest[7] == '0))
        else $error("links not in routed mode after reset");

    enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
        (wr_fire && sel_i[3]) |=> cfg_en[static_fwd_pkg::slot_link($past(slot))] ==
            $past(dat_i[static_fwd_pkg::ENABLE_BIT]))
        else $error("enable bit did not take written value");

    dest_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        (wr_fire && sel_i[0]) |=> cfg_dest[static_fwd_pkg::slot_link($past(slot))] ==
            $past(dat_i[4:0]))
        else $error("destination field did not take written value");

    slot_c_map_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
        (wr_fire && slot == 3'h0 && sel_i[3]) |=>
            cfg_en[static_fwd_pkg::LINK_C] == $past(dat_i[31]))
        else $error("first register does not control link c");

    reserved_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
        (req && !we_i && cfg_hit) |=> (ack_o && dat_o[30:5] == 26'h000_0000))
        else $error("reserved bits read nonzero");

    static_path_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
        (xfer && cfg_en[gnt_idx] && $stable(cfg_en)) |-> (push_chan && !push_route))
        else $error("static link traffic went to route path");

    static_dest_a: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
        (push_chan && chan_cnt == 2'h0 && !chan_pop && $stable(cfg_dest[gnt_idx])) |=>
            (chan_valid_o && chan_dest_o == $past(cfg_dest[gnt_idx])))
        else $error("static token delivered to wrong channel end");

    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single cycle");

endmodule

`default_nettype wire

// >>> rtl/static_fwd_pkg.sv
// constants shared by the static link forwarding block
package static_fwd_pkg;

    localparam int          NUM_LINKS   = 8;
    localparam int          LINK_IDX_W  = 3;
    localparam int          TOKEN_W     = 8;     // width of one link token
    localparam int          CHANEND_W   = 5;
    localparam int          ADR_W       = 12;
    localparam int          BUF_DEPTH   = 2;
    localparam int          CNT_W       = 16;

    // register indices; byte address is four times the index
    localparam logic [7:0]  CFG_FIRST_IDX = 8'ha0;
    localparam logic [7:0]  CFG_LAST_IDX  = 8'ha7;
    localparam logic [7:0]  STATUS_IDX    = 8'ha8;
    localparam logic [ADR_W-1:0] CFG_BASE_ADR  = {2'h0, CFG_FIRST_IDX, 2'h0};
    localparam logic [ADR_W-1:0] STATUS_ADR    = {2'h0, STATUS_IDX, 2'h0};

    // field layout of a static configuration register
    localparam int          ENABLE_BIT  = 31;
    localparam int          DEST_MSB    = 4;
    localparam int          DEST_LSB    = 0;
    localparam int          RSVD_MSB    = 30;
    localparam int          RSVD_LSB    = 5;

    // values after reset
    localparam logic                 RST_ENABLE = 1'b0;
    localparam logic [CHANEND_W-1:0] RST_DEST   = 5'h00;

    // link numbers
    localparam logic [LINK_IDX_W-1:0] LINK_A = 3'h0;
    localparam logic [LINK_IDX_W-1:0] LINK_B = 3'h1;
    localparam logic [LINK_IDX_W-1:0] LINK_C = 3'h2;
    localparam logic [LINK_IDX_W-1:0] LINK_D = 3'h3;
    localparam logic [LINK_IDX_W-1:0] LINK_E = 3'h4;
    localparam logic [LINK_IDX_W-1:0] LINK_F = 3'h5;
    localparam logic [LINK_IDX_W-1:0] LINK_G = 3'h6;
    localparam logic [LINK_IDX_W-1:0] LINK_H = 3'h7;

    // register slot to link: c, d, b, a, g, h, e, f
    function automatic logic [LINK_IDX_W-1:0] slot_link(input logic [LINK_IDX_W-1:0] slot);
        case (slot)
            3'h0:    slot_link = LINK_C;
            3'h1:    slot_link = LINK_D;
            3'h2:    slot_link = LINK_B;
            3'h3:    slot_link = LINK_A;
            3'h4:    slot_link = LINK_G;
            3'h5:    slot_link = LINK_H;
            3'h6:    slot_link = LINK_E;
            default: slot_link = LINK_F;
        endcase
    endfunction

endpackage

// >>> rtl/link_cfg_reg.sv
// one static forwarding configuration register for a single link
`timescale 1ns/1ps
`default_nettype none

module link_cfg_reg (
    input  wire logic                                   clk_i,
    input  wire logic                                   rst_i,
    input  wire logic                                   wr_i,
    input  wire logic [3:0]                             sel_i,
    input  wire logic [31:0]                            dat_i,
    output logic                                        enable_o,
    output logic [static_fwd_pkg::CHANEND_W-1:0]        dest_o
);

    // enable lives in the top byte lane, destination in the bottom one
    // RULE_01: enable bit storage
    // RULE_06: reset to routed mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_o <= static_fwd_pkg::RST_ENABLE;
        end else if (wr_i && sel_i[3]) begin
            enable_o <= dat_i[static_fwd_pkg::ENABLE_BIT];
        end
    end

    // RULE_03: destination field storage
    // RULE_05: bits 30..5 are not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dest_o <= static_fwd_pkg::RST_DEST;
        end else if (wr_i && sel_i[0]) begin
            dest_o <= dat_i[static_fwd_pkg::DEST_MSB:static_fwd_pkg::DEST_LSB];
        end
    end

endmodule

`default_nettype wire

// >>> rtl/fwd_buffer.sv
// two-entry buffer with valid and ready on both sides, outputs from flops
`timescale 1ns/1ps
`default_nettype none

module fwd_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o,
    output logic [1:0]            count_o
);

    logic [WIDTH-1:0] tail;
    logic             push;
    logic             pop;
    logic [1:0]       next_count;

    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    // occupancy after this edge
    always_comb begin
        next_count = count_o;
        if (push && !pop) begin
            next_count = count_o + 2'h1;
        end else if (pop && !push) begin
            next_count = count_o - 2'h1;
        end
    end

    // occupancy and flags kept as flops so no output is combinational
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o     <= 2'h0;
            out_valid_o <= 1'b0;
            in_ready_o  <= 1'b1;
        end else begin
            count_o     <= next_count;
            out_valid_o <= (next_count != 2'h0);
            in_ready_o  <= (next_count != 2'h2);
        end
    end

    // head is the output register, tail holds the word that arrived during a stall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_data_o <= '0;
            tail       <= '0;
        end else begin
            if (pop) begin
                out_data_o <= (count_o == 2'h2) ? tail : in_data_i;
            end else if (push && count_o == 2'h0) begin
                out_data_o <= in_data_i;
            end
            if (push && (count_o == 2'h2 || (count_o == 2'h1 && !pop))) begin
                tail <= in_data_i;
            end else if (push && count_o == 2'h2 && pop) begin
                tail <= in_data_i;
            end
        end
    end

    buffer_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        count_o != 2'h3)
        else $error("buffer occupancy out of range");

endmodule

`default_nettype wire

// >>> testbench/link_peer.sv
// remote link ends: present tokens on each link and hold them until granted
`timescale 1ns/1ps
`default_nettype none

module link_peer (
    input  wire logic        clk_i,
    input  wire logic [7:0]  link_ready_i,
    output var  logic [7:0]  link_valid_o,
    output var  logic [63:0] link_data_o
);
    initial begin
        link_valid_o = 8'h00;
        link_data_o  = 64'h5a5a_a5a5_5a5a_a5a5;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one token: optional idle gap, then valid and data held up to the taking edge;
    // afterwards the lane shows the inverse so a stale token never looks live
    task automatic send(input int l, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        link_valid_o[l]       <= 1'b1;
        link_data_o[l*8 +: 8] <= d;
        // ready is read right at the edge, before it updates: the value the edge samples
        do @(posedge clk_i); while (link_ready_i[l] !== 1'b1);
        link_valid_o[l]       <= 1'b0;
        link_data_o[l*8 +: 8] <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> testbench/static_link_fwd_tb_top.sv
// self-checking testbench for the static link forwarding block
`timescale 1ns/1ps
`default_nettype none

module static_link_fwd_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] bus_q;
    logic        ack;
    logic [7:0]  lval;
    logic [63:0] ldat;
    logic [7:0]  lrdy;
    logic        chan_val;
    logic        chan_rdy = 1'b0;
    logic [7:0]  ctok;
    logic [4:0]  cdest;
    logic        route_val;
    logic        route_rdy = 1'b0;
    logic [7:0]  rtok;
    logic [2:0]  rlink;
    logic [12:0] chan_q[$];
    logic [12:0] route_q[$];
    int          n_mismatch = 0;
    int          n_checks = 0;
    int          sink_mode = 0;    // 0 free, 1 slow, 2 blocked
    int          cnt = 0;
    int          lk[8] = '{2, 3, 1, 0, 6, 7, 4, 5};    // slot to link number

    always #5 clk = ~clk;

    static_link_fwd u_dut (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(bus_q), .ack_o(ack),
        .link_valid_i(lval), .link_data_i(ldat), .link_ready_o(lrdy),
        .chan_valid_o(chan_val), .chan_ready_i(chan_rdy), .chan_data_o(ctok),
        .chan_dest_o(cdest), .route_valid_o(route_val), .route_ready_i(route_rdy),
        .route_data_o(rtok), .route_link_o(rlink)
    );

    link_peer u_peer (
        .clk_i(clk), .link_ready_i(lrdy), .link_valid_o(lval), .link_data_o(ldat)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sinks: the stall pattern exercises the buffer without ever dropping a token
    always @(posedge clk) begin
        cnt       <= cnt + 1;
        chan_rdy  <= (sink_mode == 0) || (sink_mode == 1 && cnt[1:0] == 2'h0);
        route_rdy <= (sink_mode == 0) || (sink_mode == 1 && cnt[0]);
        if (chan_val === 1'b1 && chan_rdy) chan_q.push_back({cdest, ctok});
        if (route_val === 1'b1 && route_rdy) route_q.push_back({2'h0, rlink, rtok});
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // classic single cycle; ack and read data are read right at each rising edge,
    // before that edge's updates land, so they are exactly what the edge samples
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= s;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 100);
        if (t >= 100) n_mismatch++;
        q = bus_q;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb(1'b1, a, d, s, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, 4'hf, q);
        chk($sformatf("reg %h", a), exp, q);
    endtask

    task automatic pop(ref logic [12:0] q[$], input string nm, input logic [12:0] exp);
        int t;
        t = 0;
        while (q.size() == 0 && t < 200) begin
            @(posedge clk);
            t++;
        end
        if (q.size() == 0) chk(nm, {19'h0, exp}, 32'hffff_ffff);
        else chk(nm, {19'h0, exp}, {19'h0, q.pop_front()});
    endtask

    function automatic logic [11:0] slot_adr(input int k);
        return 12'h280 + 12'(4 * k);
    endfunction

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 8; k++) rd(slot_adr(k), 32'h0);
        rd(12'h300, 32'h0);
        wr(12'h300, 32'hffff_ffff, 4'hf);
        rd(12'h300, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(slot_adr(k), 32'hffff_ffe0 | 32'(k + 8), 4'hf);
            rd(slot_adr(k), 32'h8000_0000 | 32'(k + 8));
        end
        // each slot steers its own link to a distinct channel end
        for (int k = 0; k < 8; k++) begin
            u_peer.send(lk[k], 8'(8'h10 + k), k % 2);
            pop(chan_q, "chan token", {5'(k + 8), 8'(8'h10 + k)});
        end
        chk("routed count", 32'h0, 32'(route_q.size()));
        // status word: routed count high half, static count low half
        rd(12'h2a0, 32'h0000_0008);
        wr(slot_adr(0), 32'h0000_0005, 4'hf);
        rd(slot_adr(0), 32'h0000_0005);
        u_peer.send(2, 8'ha5, 0);
        pop(route_q, "route token", {2'h0, 3'h2, 8'ha5});
        wr(slot_adr(1), 32'h0000_0003, 4'h1);
        rd(slot_adr(1), 32'h8000_0003);
        // fill the buffer with the sink blocked, then drain it slowly
        sink_mode <= 2;
        fork
            for (int i = 0; i < 3; i++) u_peer.send(3, 8'(8'h40 + i), 0);
        join_none
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("grant while full", 32'h0, {31'h0, lrdy[3]});
        chk("held tokens", 32'h0, 32'(chan_q.size()));
        sink_mode = 1;
        wait fork;
        for (int i = 0; i < 3; i++) pop(chan_q, "drained token", {5'h03, 8'(8'h40 + i)});
        sink_mode <= 0;
        // eleven static words and one routed word so far
        rd(12'h2a0, 32'h0001_000b);
        // second reset in mid-run clears the configuration again
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(slot_adr(1), 32'h0);
        rd(12'h2a0, 32'h0);
        end_sim;
    end

    // watchdog: the sequence needs a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim;
    end
endmodule
`default_nettype wire
